/* File: hw/dcp_data_cache.sv */
// Data cache line-state and snoop protocol controller
`timescale 1ns/100ps
module dcp_data_cache
    import dcp_pkg::*;
#(
    parameter int SETS = DCP_SETS_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cache_en,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [31:0] cpu_addr,
    input wire logic [31:0] cpu_wdata,
    input wire logic [3:0] cpu_be,
    input wire logic [1:0] cpu_mode,
    input wire logic cpu_special,
    input wire logic block_move_instr,
    input wire logic cpu_locked,
    output logic cpu_ack,
    output logic [31:0] cpu_rdata,
    output logic bus_req,
    output logic bus_we,
    output logic bus_line,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata,
    output logic [3:0] bus_be,
    input wire logic bus_ack,
    input wire logic [31:0] bus_rdata,
    input wire logic snp_valid,
    input wire logic snp_we,
    input wire logic snp_line,
    input wire logic [31:0] snp_addr,
    input wire logic [31:0] snp_wdata,
    input wire logic [3:0] snp_be,
    input wire logic snp_ctrl_hi,
    input wire logic snp_ctrl_lo,
    output logic snp_done,
    output logic snp_inhibit,
    output logic [31:0] snp_rdata
);
    localparam int IW = $clog2(SETS);
    localparam int TW = 32 - DCP_LINE_LSB - IW;

    typedef struct packed {
        dcp_state_e st;
        logic [1:0] cnt;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic we;
        logic lock_skip;
        logic cpu_ack;
        logic [31:0] cpu_rdata;
        logic bus_req;
        logic bus_we;
        logic bus_line;
        logic [31:0] bus_addr;
        logic [31:0] bus_wdata;
        logic [3:0] bus_be;
        logic snp_done;
        logic snp_inhibit;
        logic [31:0] snp_rdata;
        logic [SETS-1:0] vld;
        logic [SETS-1:0][3:0] dbits;
    } dcp_regs_s;
    dcp_regs_s r;
    dcp_regs_s next_r;
    // Tag and data storage, no reset needed behind the valid bits
    logic [TW-1:0] tag_q [SETS];
    logic [31:0] data_q [SETS*4];
    // Array write ports and decoded lookups
    logic m_dwe, m_twe, s_hit, s_dirty, c_hit, c_cachable, c_no_alloc;
    logic [IW+1:0] m_didx;
    logic [31:0] m_dwd, fill_wd;
    logic [IW-1:0] m_tidx, s_idx, c_idx, r_idx;
    logic [TW-1:0] m_twd;
    logic [1:0] snp_ctrl, c_word;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [IW-1:0] idx_of(input logic [31:0] a);
        return a[DCP_LINE_LSB +: IW];
    endfunction
    function automatic logic [TW-1:0] tag_of(input logic [31:0] a);
        return a[31 -: TW];
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old_d, input logic [31:0] new_d,
                                         input logic [3:0] be);
        logic [31:0] res;
        res = old_d;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_d[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_r = r;
        next_r.cpu_ack = 1'b0;
        next_r.snp_done = 1'b0;
        next_r.snp_inhibit = 1'b0;
        m_dwe = 1'b0;
        m_didx = '0;
        m_dwd = '0;
        m_twe = 1'b0;
        m_tidx = '0;
        m_twd = '0;
        snp_ctrl = {snp_ctrl_hi, snp_ctrl_lo};
        s_idx = idx_of(snp_addr);
        s_hit = r.vld[s_idx] && (tag_q[s_idx] == tag_of(snp_addr));
        s_dirty = |r.dbits[s_idx];
        c_idx = idx_of(cpu_addr);
        c_hit = r.vld[c_idx] && (tag_q[c_idx] == tag_of(cpu_addr));
        c_word = cpu_addr[DCP_WORD_SEL_LSB +: 2];
        c_cachable = cache_en && (cpu_mode == DCP_MODE_WT || cpu_mode == DCP_MODE_CB);
        c_no_alloc = cpu_special || block_move_instr
                     || (r.lock_skip && !cpu_locked);
        r_idx = idx_of(r.addr);
        fill_wd = bus_rdata;
        case (r.st)
            DCP_ST_IDLE: begin
                // Snoop takes the arrays first, cache enable ignored
                if (snp_valid) begin
                    next_r.snp_done = 1'b1;
                    // Off and reserved codes fall through untouched
                    if (s_hit && (snp_ctrl == DCP_SNP_SUPPLY_SINK
                                  || snp_ctrl == DCP_SNP_MARK_INVAL)) begin
                        if (!snp_we) begin
                            // Dirty read hit: memory held off, cache sources data
                            if (s_dirty) begin
                                next_r.snp_inhibit = 1'b1;
                                next_r.snp_rdata = data_q[{s_idx, snp_addr[3:2]}];
                            end
                            // Mark-invalid kills the line after this beat
                            if (snp_ctrl == DCP_SNP_MARK_INVAL) begin
                                next_r.vld[s_idx] = 1'b0;
                                next_r.dbits[s_idx] = '0;
                            end
                        end else if (snp_ctrl == DCP_SNP_MARK_INVAL || snp_line
                                     || !s_dirty) begin
                            next_r.vld[s_idx] = 1'b0;
                            next_r.dbits[s_idx] = '0;
                        end else begin
                            // Sink a small write into the dirty line
                            next_r.snp_inhibit = 1'b1;
                            m_dwe = 1'b1;
                            m_didx = {s_idx, snp_addr[3:2]};
                            m_dwd = merge(data_q[{s_idx, snp_addr[3:2]}], snp_wdata, snp_be);
                            next_r.dbits[s_idx][snp_addr[3:2]] = 1'b1;
                        end
                    end
                end else if (cpu_req && !r.cpu_ack) begin
                    next_r.addr = cpu_addr;
                    next_r.wdata = cpu_wdata;
                    next_r.be = cpu_be;
                    next_r.we = cpu_we;
                    next_r.cnt = DCP_FIRST_BEAT;
                    // Locked hit with cache off arms the skip
                    if (!cache_en && cpu_locked && c_hit) begin
                        next_r.lock_skip = 1'b1;
                    end
                    if (c_cachable && !cpu_locked && !c_hit) begin
                        next_r.lock_skip = 1'b0;
                    end
                    if (c_cachable && c_hit && !cpu_we) begin
                        // Read hit, one long word per access
                        next_r.cpu_ack = 1'b1;
                        next_r.cpu_rdata = data_q[{c_idx, c_word}];
                    end else if (c_cachable && c_hit && block_move_instr) begin
                        // Block move write hit drops the line
                        next_r.vld[c_idx] = 1'b0;
                        next_r.dbits[c_idx] = '0;
                        next_r.st = DCP_ST_SINGLE;
                    end else if (c_cachable && c_hit) begin
                        // Data side only; instruction side never observes
                        m_dwe = 1'b1;
                        m_didx = {c_idx, c_word};
                        m_dwd = merge(data_q[{c_idx, c_word}], cpu_wdata, cpu_be);
                        if (cpu_mode == DCP_MODE_CB) begin
                            next_r.dbits[c_idx][c_word] = 1'b1;
                            next_r.cpu_ack = 1'b1;
                        end else begin
                            next_r.st = DCP_ST_SINGLE;
                        end
                    end else if (c_cachable && !c_no_alloc
                                 && !(cpu_we && cpu_mode == DCP_MODE_WT)) begin
                        // Allocate: push a dirty victim first, then fill
                        if (r.vld[c_idx] && (|r.dbits[c_idx])) begin
                            next_r.st = DCP_ST_PUSH;
                            next_r.bus_we = 1'b1;
                            next_r.bus_line = 1'b0;
                            next_r.bus_be = DCP_ALL_BYTES;
                            next_r.bus_addr = {tag_q[c_idx], c_idx, DCP_FIRST_BEAT, 2'h0};
                            next_r.bus_wdata = data_q[{c_idx, DCP_FIRST_BEAT}];
                        end else begin
                            next_r.st = DCP_ST_FILL;
                            next_r.bus_we = 1'b0;
                            next_r.bus_line = 1'b1;
                            next_r.bus_be = DCP_ALL_BYTES;
                            next_r.bus_addr = {cpu_addr[31:4], 4'h0};
                        end
                        next_r.bus_req = 1'b1;
                    end else begin
                        // Bypass: uncached access or non-allocating miss
                        next_r.st = DCP_ST_SINGLE;
                    end
                    if (next_r.st == DCP_ST_SINGLE) begin
                        next_r.bus_req = 1'b1;
                        next_r.bus_we = cpu_we;
                        next_r.bus_line = 1'b0;
                        next_r.bus_be = cpu_be;
                        next_r.bus_addr = cpu_addr;
                        next_r.bus_wdata = cpu_wdata;
                    end
                end
            end
            DCP_ST_SINGLE: begin
                // One long-word bus access, then answer the core
                if (bus_ack) begin
                    next_r.bus_req = 1'b0;
                    next_r.cpu_ack = 1'b1;
                    if (!r.we) begin
                        next_r.cpu_rdata = bus_rdata;
                    end
                    next_r.st = DCP_ST_IDLE;
                end
            end
            DCP_ST_PUSH: begin
                // Victim written out word by word
                if (bus_ack) begin
                    if (r.cnt == DCP_LAST_BEAT) begin
                        next_r.vld[r_idx] = 1'b0;
                        next_r.dbits[r_idx] = '0;
                        next_r.cnt = DCP_FIRST_BEAT;
                        next_r.st = DCP_ST_FILL;
                        next_r.bus_we = 1'b0;
                        next_r.bus_line = 1'b1;
                        next_r.bus_addr = {r.addr[31:4], 4'h0};
                    end else begin
                        next_r.cnt = r.cnt + 2'h1;
                        next_r.bus_addr[3:2] = r.cnt + 2'h1;
                        next_r.bus_wdata = data_q[{r_idx, 2'(r.cnt + 2'h1)}];
                    end
                end
            end
            DCP_ST_FILL: begin
                // Beats arrive in word order; the core's word is captured and, on a write, merged
                if (bus_ack) begin
                    if (r.cnt == r.addr[3:2]) begin
                        next_r.cpu_rdata = bus_rdata;
                        if (r.we) begin
                            fill_wd = merge(bus_rdata, r.wdata, r.be);
                        end
                    end
                    m_dwe = 1'b1;
                    m_didx = {r_idx, r.cnt};
                    m_dwd = fill_wd;
                    next_r.cnt = r.cnt + 2'h1;
                    if (r.cnt == DCP_LAST_BEAT) begin
                        next_r.bus_req = 1'b0;
                        next_r.bus_line = 1'b0;
                        m_twe = 1'b1;
                        m_tidx = r_idx;
                        m_twd = tag_of(r.addr);
                        next_r.vld[r_idx] = 1'b1;
                        next_r.dbits[r_idx] = r.we ? 4'(4'h1 << r.addr[3:2]) : 4'h0;
                        next_r.cpu_ack = 1'b1;
                        next_r.st = DCP_ST_IDLE;
                    end
                end
            end
            default: begin
                next_r.st = DCP_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Array writes
    always_ff @(posedge clk_sys) begin
        if (m_dwe) begin
            data_q[m_didx] <= m_dwd;
        end
        if (m_twe) begin
            tag_q[m_tidx] <= m_twd;
        end
    end

    // Outputs straight from the state flops
    assign cpu_ack = r.cpu_ack;
    assign cpu_rdata = r.cpu_rdata;
    assign bus_req = r.bus_req;
    assign bus_we = r.bus_we;
    assign bus_line = r.bus_line;
    assign bus_addr = r.bus_addr;
    assign bus_wdata = r.bus_wdata;
    assign bus_be = r.bus_be;
    assign snp_done = r.snp_done;
    assign snp_inhibit = r.snp_inhibit;
    assign snp_rdata = r.snp_rdata;

endmodule // dcp_data_cache

/* File: hw/dcp_pkg.sv */
// Shared constants and types for the data cache protocol controller
package dcp_pkg;
    // Geometry defaults
    localparam int DCP_SETS_DEF = 16;
    localparam int DCP_WORD_SEL_LSB = 2;
    localparam int DCP_HALF_LINE_BIT = 3;
    localparam int DCP_LINE_LSB = 4;
    localparam logic [1:0] DCP_LAST_BEAT = 2'h3;
    localparam logic [1:0] DCP_FIRST_BEAT = 2'h0;
    localparam logic [3:0] DCP_ALL_BYTES = 4'hF;
    // Page caching modes
    localparam logic [1:0] DCP_MODE_WT = 2'h0;
    localparam logic [1:0] DCP_MODE_CB = 2'h1;
    localparam logic [1:0] DCP_MODE_NSER = 2'h2;
    localparam logic [1:0] DCP_MODE_SER = 2'h3;
    // Snoop control encodings {hi, lo}
    localparam logic [1:0] DCP_SNP_OFF = 2'h0;
    localparam logic [1:0] DCP_SNP_SUPPLY_SINK = 2'h1;
    localparam logic [1:0] DCP_SNP_MARK_INVAL = 2'h2;
    localparam logic [1:0] DCP_SNP_RSVD = 2'h3;
    // Controller states; first state is the reset state
    typedef enum logic [1:0] {
        DCP_ST_IDLE,
        DCP_ST_PUSH,
        DCP_ST_FILL,
        DCP_ST_SINGLE
    } dcp_state_e;
endpackage

/* File: verification/dcp_data_cache_props.sv */
// Port protocol checker for the data cache protocol controller
`timescale 1ns/100ps
module dcp_data_cache_props (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cpu_req,
    input wire logic cpu_ack,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic bus_line,
    input wire logic [31:0] bus_addr,
    input wire logic bus_ack,
    input wire logic snp_valid,
    input wire logic snp_ctrl_hi,
    input wire logic snp_ctrl_lo,
    input wire logic snp_done,
    input wire logic snp_inhibit
);
    default clocking dflt @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////////
    // Snoop answers
    property p_snp_done; snp_valid |=> snp_done; endproperty
    a_snp_done: assert property (p_snp_done) else $error("snoop beat not answered");
    property p_snp_quiet; !snp_valid |=> !snp_done && !snp_inhibit; endproperty
    a_snp_quiet: assert property (p_snp_quiet) else $error("snoop answer without beat");
    property p_inh_off; snp_valid && (snp_ctrl_hi == snp_ctrl_lo) |=> !snp_inhibit; endproperty
    a_inh_off: assert property (p_inh_off) else $error("inhibit on disabled snoop");
    property p_snp_first; snp_valid && cpu_req && !bus_req && !cpu_ack |=> !cpu_ack; endproperty
    a_snp_first: assert property (p_snp_first) else $error("core served before snoop");
    ////////////////////////////////////////////////////////////////////////////////////
    // Bus and core handshakes
    property p_bus_hold; bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus request changed early");
    property p_line_rd; bus_line |-> bus_req && !bus_we; endproperty
    a_line_rd: assert property (p_line_rd) else $error("line transfer not a read");
    property p_fill_ack; $fell(bus_line) |-> cpu_ack; endproperty
    a_fill_ack: assert property (p_fill_ack) else $error("no ack after line fill");
    property p_ack_pulse; cpu_ack |-> !bus_req ##1 !cpu_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_req; cpu_ack |-> $past(cpu_req); endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    c_inhibit: cover property (snp_inhibit);
    c_fill: cover property ($fell(bus_line));
    c_clash: cover property (snp_valid && cpu_req);
endmodule // dcp_data_cache_props

/* File: verification/dcp_mem_model.sv */
// Memory side model answering the controller's bus requests
`timescale 1ns/100ps
module dcp_mem_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic bus_line,
    input wire logic [31:0] bus_addr,
    output logic bus_ack,
    output logic [31:0] bus_rdata,
    output int n_wb,
    output int n_rb
);
    logic [1:0] wait_cnt;
    logic [1:0] beat;
    ////////////////////////////////////////////////////////////////////////////////////
    // One ack per beat, never two in a row; slow adds wait states
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_ack <= 1'b0;
            bus_rdata <= 32'h0;
            wait_cnt <= 2'h0;
            beat <= 2'h0;
            n_wb <= 0;
            n_rb <= 0;
        end else begin
            bus_ack <= 1'b0;
            bus_rdata <= ~bus_rdata; // Released data never keeps its value
            if (!bus_req) begin
                beat <= 2'h0;
            end else if (!bus_ack && wait_cnt != (slow ? 2'h3 : 2'h0)) begin
                wait_cnt <= wait_cnt + 2'h1;
            end else if (!bus_ack) begin
                bus_ack <= 1'b1;
                wait_cnt <= 2'h0;
                bus_rdata <= (bus_addr + (bus_line ? {28'h0, beat, 2'h0} : 32'h0)) ^ 32'h5A5A5A5A;
                beat <= beat + 2'h1;
                n_wb <= n_wb + (bus_we ? 1 : 0);
                n_rb <= n_rb + (bus_we ? 0 : 1);
            end
        end
    end
endmodule // dcp_mem_model

/* File: verification/tb_top.sv */
// Self-checking bench for the data cache protocol controller
`timescale 1ns/100ps
module tb_top;
    import dcp_pkg::*;
    typedef struct packed {
        logic [1:0] op;
        logic en;
        logic [2:0] fl;
        logic [1:0] md;
        logic [1:0] sc;
        logic ln;
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic [3:0] nw;
        logic [3:0] nr;
    } dcp_row_s;
    localparam logic [31:0] D1 = 32'h11111111;
    localparam logic [31:0] D2 = 32'h22222222;
    localparam logic [31:0] D3 = 32'h33333333;
    localparam logic [31:0] D4 = 32'h44444444;
    // Fields: op en flags mode snoop_code line addr wdata expected writes_or_inhibit reads
    localparam dcp_row_s ROWS [38] = '{
        '{0,1,0,1,0,0,'h110,0,0,0,4}, '{0,1,0,1,0,0,'h118,0,0,0,0},
        '{1,1,0,1,0,0,'h114,D1,0,0,0}, '{0,1,0,1,0,0,'h114,0,D1,0,0},
        '{2,1,0,0,1,0,'h114,0,D1,1,15}, '{2,1,0,0,0,0,'h114,0,0,0,15},
        '{2,1,0,0,3,0,'h114,0,0,0,15}, '{3,1,0,0,1,0,'h118,D2,0,1,15},
        '{3,1,0,0,0,0,'h118,D3,0,0,15}, '{0,1,0,1,0,0,'h118,0,D2,0,0},
        '{2,1,0,0,1,0,'h210,0,0,0,15}, '{3,1,0,0,1,0,'h21C,D3,0,0,15},
        '{2,0,0,0,2,1,'h114,0,D1,1,15}, '{0,1,0,1,0,0,'h110,0,0,0,4},
        '{1,1,0,0,0,0,'h124,D3,0,1,0}, '{0,1,0,0,0,0,'h124,0,0,0,4},
        '{1,1,0,0,0,0,'h128,D3,0,1,0}, '{0,1,0,0,0,0,'h128,0,D3,0,0},
        '{3,1,0,0,2,0,'h128,D4,0,0,15}, '{0,1,0,0,0,0,'h128,0,0,0,4},
        '{3,1,0,0,1,1,'h120,D4,0,0,15}, '{0,1,0,0,0,0,'h12C,0,0,0,4},
        '{1,1,0,1,0,0,'h134,D4,0,0,4}, '{2,1,0,0,1,0,'h134,0,D4,1,15},
        '{0,1,0,1,0,0,'h130,0,0,0,0}, '{0,1,0,1,0,0,'h1130,0,0,4,4},
        '{0,1,4,1,0,0,'h140,0,0,0,15}, '{0,1,0,1,0,0,'h140,0,0,0,4},
        '{0,1,2,1,0,0,'h150,0,0,0,15}, '{0,1,0,1,0,0,'h150,0,0,0,4},
        '{0,1,2,1,0,0,'h154,0,0,0,0}, '{1,1,2,1,0,0,'h154,D1,0,1,0},
        '{0,1,0,1,0,0,'h154,0,0,0,4}, '{0,0,1,1,0,0,'h154,0,0,0,15},
        '{0,1,0,1,0,0,'h160,0,0,0,15}, '{0,1,0,1,0,0,'h160,0,0,0,4},
        '{0,0,0,1,0,0,'h170,0,0,0,1}, '{0,1,0,2,0,0,'h174,0,0,0,1}};
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic cache_en, cpu_req, cpu_we, cpu_special, block_move_instr, cpu_locked, slow;
    logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, bus_addr, bus_wdata, bus_rdata;
    logic [31:0] snp_addr, snp_wdata, snp_rdata;
    logic [3:0] cpu_be, bus_be, snp_be;
    logic [1:0] cpu_mode;
    logic cpu_ack, bus_req, bus_we, bus_line, bus_ack;
    logic snp_valid, snp_we, snp_line, snp_ctrl_hi, snp_ctrl_lo, snp_done, snp_inhibit;
    int bad_count = 0;
    int total_checks = 0;
    int n_wb, n_rb, w0, r0;
    // Free-running system clock
    always #5 clk_sys = ~clk_sys;
    dcp_data_cache dcp_data_cache_i (.clk_sys(clk_sys), .rst_b(rst_b), .cache_en(cache_en),
        .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_be(cpu_be), .cpu_mode(cpu_mode), .cpu_special(cpu_special),
        .block_move_instr(block_move_instr), .cpu_locked(cpu_locked), .cpu_ack(cpu_ack),
        .cpu_rdata(cpu_rdata), .bus_req(bus_req), .bus_we(bus_we), .bus_line(bus_line),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .snp_valid(snp_valid), .snp_we(snp_we), .snp_line(snp_line),
        .snp_addr(snp_addr), .snp_wdata(snp_wdata), .snp_be(snp_be),
        .snp_ctrl_hi(snp_ctrl_hi), .snp_ctrl_lo(snp_ctrl_lo), .snp_done(snp_done),
        .snp_inhibit(snp_inhibit), .snp_rdata(snp_rdata));
    dcp_mem_model dcp_mem_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow),
        .bus_req(bus_req), .bus_we(bus_we), .bus_line(bus_line), .bus_addr(bus_addr),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .n_wb(n_wb), .n_rb(n_rb));
    ////////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] pat(input logic [15:0] a);
        return {16'h0, a} ^ 32'h5A5A5A5A;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_ack();
        for (int i = 0; i < 300 && cpu_ack !== 1'b1; i++) @(negedge clk_sys);
        if (cpu_ack !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        cpu_req = 1'b0;
    endtask
    task automatic cpu_op(input dcp_row_s r);
        @(negedge clk_sys);
        {cpu_special, block_move_instr, cpu_locked} = r.fl;
        {cache_en, cpu_we, cpu_mode} = {r.en, r.op[0], r.md};
        {cpu_addr, cpu_wdata} = {16'h0, r.a, r.d};
        cpu_req = 1'b1;
        wait_ack();
    endtask
    task automatic snp_op(input dcp_row_s r);
        @(negedge clk_sys);
        {cache_en, snp_we, snp_line, snp_ctrl_hi, snp_ctrl_lo} = {r.en, r.op[0], r.ln, r.sc};
        {snp_addr, snp_wdata} = {16'h0, r.a, r.d};
        snp_valid = 1'b1;
        @(negedge clk_sys);
        snp_valid = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    // Main sequence: table rows, then priority and reset cases
    initial begin
        dcp_row_s r;
        {cache_en, cpu_req, cpu_we, cpu_special, block_move_instr, cpu_locked, slow} = 7'h0;
        {cpu_addr, cpu_wdata, snp_addr, snp_wdata, cpu_mode} = 130'h0;
        {cpu_be, snp_be} = 8'hFF;
        {snp_valid, snp_we, snp_line, snp_ctrl_hi, snp_ctrl_lo} = 5'h0;
        repeat (2) @(negedge clk_sys);
        chk("outputs in reset", {bus_req, cpu_ack, snp_done, snp_inhibit}, 32'h0);
        rst_b = 1'b1;
        foreach (ROWS[k]) begin
            r = ROWS[k];
            slow = k[0];
            {w0, r0} = {n_wb, n_rb};
            if (r.op[1]) begin
                snp_op(r);
                chk("snoop inhibit", {31'h0, snp_inhibit}, {28'h0, r.nw});
                if (r.nw == 4'h1 && !r.op[0]) chk("snoop data", snp_rdata, r.x);
            end else begin
                cpu_op(r);
                if (!r.op[0]) chk("read data", cpu_rdata, r.x != 0 ? r.x : pat(r.a));
                chk("bus writes", n_wb - w0, {28'h0, r.nw});
                if (r.op[0] && r.nw == 4'h1) begin
                    chk("bus data", bus_wdata, r.d);
                    chk("bus enables", {28'h0, bus_be}, 32'hF);
                end
                if (r.nr != 4'hF) chk("bus reads", n_rb - r0, {28'h0, r.nr});
            end
        end
        // Snoop and core request in the same cycle
        @(negedge clk_sys);
        {cpu_special, block_move_instr, cpu_locked, cache_en, cpu_we} = 5'h2;
        {cpu_addr, snp_addr, cpu_mode} = {32'h118, 32'h118, DCP_MODE_CB};
        {snp_we, snp_line, snp_ctrl_hi, snp_ctrl_lo} = {2'h0, DCP_SNP_SUPPLY_SINK};
        {cpu_req, snp_valid} = 2'h3;
        @(negedge clk_sys);
        snp_valid = 1'b0;
        chk("snoop first", {snp_done, cpu_ack}, 32'h2);
        wait_ack();
        chk("read data", cpu_rdata, pat(16'h0118));
        // Reset in mid-run clears every line
        @(negedge clk_sys);
        rst_b = 1'b0;
        @(negedge clk_sys);
        chk("outputs in reset", {bus_req, cpu_ack, snp_done}, 32'h0);
        rst_b = 1'b1;
        r0 = n_rb;
        cpu_op(ROWS[1]);
        chk("bus reads", n_rb - r0, 32'h4);
        end_sim();
    end
endmodule // tb_top
bind dcp_data_cache dcp_data_cache_props dcp_data_cache_props_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .cpu_req(cpu_req), .cpu_ack(cpu_ack), .bus_req(bus_req), .bus_we(bus_we),
    .bus_line(bus_line), .bus_addr(bus_addr), .bus_ack(bus_ack), .snp_valid(snp_valid),
    .snp_ctrl_hi(snp_ctrl_hi), .snp_ctrl_lo(snp_ctrl_lo), .snp_done(snp_done),
    .snp_inhibit(snp_inhibit));
